// ### include/sfsr_map.svh
// Purpose: offsets, bit positions, reset values and timing figures of the fault status bank
// Assumes: included by bare name
// Notes: definitions only
`ifndef SFSR_MAP_SVH
`define SFSR_MAP_SVH

`define SFSR_ADDR_W 8
`define SFSR_DATA_W 8
`define SFSR_OFF_SUPPLY 8'h02
`define SFSR_OFF_MEMTEMP 8'h03
`define SFSR_BIT_SEAL 0
`define SFSR_BIT_FOTP 7
`define SFSR_BIT_UOTP 6
`define SFSR_BIT_URW 5
`define SFSR_BIT_UWACT 4
`define SFSR_BIT_TEMP 2
`define SFSR_REG_RST 8'h00
`define SFSR_CLK_MHZ 20
`define SFSR_RCV_PERIOD_US 1000
`define SFSR_RCV_CNT_W 24
`define SFSR_CODE_W 16
`define SFSR_CODE_SEED 16'hffff
`define SFSR_CODE_POLY 16'h1021

`endif

// ### include/sfsr_pkg.sv
// Purpose: shared types of the fault status bank
// Assumes: sfsr_map.svh gives the widths
// Notes: one packed struct per group of related signals
`include "sfsr_map.svh"

package sfsr_pkg;

    // fault condition levels from the sensing circuits
    typedef struct packed {
        logic edge_seal_break;
        logic other_supply_fault;
        logic factory_otp_fault;
        logic user_otp_fault;
        logic otp_write_busy;
        logic temperature_out_of_range;
    } sfsr_fault_t;

    // one-cycle pulses from the serial side: a status field reported these errors
    typedef struct packed {
        logic supply;
        logic factory_otp;
        logic user_otp;
        logic user_reg_check;
        logic temperature;
    } sfsr_tx_clear_t;

    typedef enum logic [1:0] {
        SFSR_CHK_IDLE,
        SFSR_CHK_ARM,
        SFSR_CHK_RUN
    } sfsr_chk_state_t;

    typedef struct packed {
        sfsr_chk_state_t st;
        logic [`SFSR_CODE_W-1:0] ref_code;
        logic mismatch;
    } sfsr_chk_t;

    typedef struct packed {
        logic [`SFSR_RCV_CNT_W-1:0] rcv_cnt;
        logic timer_running;
        logic seal;
        logic f_otp;
        logic u_otp;
        logic u_rw;
        logic temp;
        logic summary;
        logic [`SFSR_DATA_W-1:0] rd_data;
    } sfsr_state_t;

endpackage : sfsr_pkg

// ### verilog/sfsr_check_code.sv
// Purpose: check code over the user-writable registers and comparison with a reference
// Assumes: user register image is a flat vector, lock only rises after reset
// Notes: reference captured one cycle after the lock is seen
`timescale 1ns/10ps
`default_nettype none
`include "sfsr_map.svh"

module sfsr_check_code
    import sfsr_pkg::*;
#(
    parameter int NUM_REGS = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic init_done_lock,
    input wire logic [NUM_REGS*8-1:0] user_regs,
    output logic mismatch
);

    sfsr_chk_t s_q;
    sfsr_chk_t s_d;
    logic [`SFSR_CODE_W-1:0] code;

    // crc over every byte, folded in one cycle
    function automatic logic [`SFSR_CODE_W-1:0] sfsr_crc(input logic [NUM_REGS*8-1:0] v);
        logic [`SFSR_CODE_W-1:0] c;
        c = `SFSR_CODE_SEED;
        for (int i = 0; i < NUM_REGS * 8; i++) begin
            if (c[`SFSR_CODE_W-1] ^ v[i]) begin
                c = {c[`SFSR_CODE_W-2:0], 1'b0} ^ `SFSR_CODE_POLY;
            end else begin
                c = {c[`SFSR_CODE_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction : sfsr_crc

    assign code = sfsr_crc(user_regs);
    assign mismatch = s_q.mismatch;

    always_comb begin
        s_d = s_q;
        s_d.mismatch = 1'b0;
        case (s_q.st)
            SFSR_CHK_IDLE: begin
                if (init_done_lock) begin
                    s_d.st = SFSR_CHK_ARM;
                end
            end
            SFSR_CHK_ARM: begin
                s_d.ref_code = code;
                s_d.st = SFSR_CHK_RUN;
            end
            SFSR_CHK_RUN: begin
                s_d.mismatch = (code != s_q.ref_code);
            end
            default: begin
                s_d.st = SFSR_CHK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{st: SFSR_CHK_IDLE, ref_code: '0, mismatch: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sfsr_check_code
`default_nettype wire

// ### verilog/sfsr_status_regs.sv
// Purpose: supply and memory/temperature fault status registers with their clear logic
// Assumes: fault inputs synchronous to clk_sys; read strobe and tx clears are one-cycle pulses
// Notes: lock and disable controls come from the lock register outside this block
`timescale 1ns/10ps
`default_nettype none
`include "sfsr_map.svh"

// Functional notes
// - edge seal break sets supply status bit 0, otherwise it stays zero.
// - one shared recovery timer serves every supply status error bit.
// - any present supply fault reloads the timer to the full recovery period.
// - supply bits clear according to the supply report disable control.
// - factory OTP fault sets memory/temperature status bit 7.
// - user OTP fault sets memory/temperature status bit 6.
// - OTP, check and temperature bits clear on register read or reporting transmission.
// - after init lock, check code over user registers is compared continuously.
// - check code mismatch sets memory/temperature status bit 5.
// - bit 4 is high while a user OTP write is in progress.
// - bit 4 clears itself when the write ends, reads do not clear it.
// - over or under temperature sets memory/temperature status bit 2.
// - summary flag is the OR of all memory/temperature status bits.
module sfsr_status_regs
    import sfsr_pkg::*;
#(
    parameter int NUM_USER_REGS = 16,
    parameter int RCV_PERIOD_US = `SFSR_RCV_PERIOD_US,
    parameter int RCV_CYCLES = RCV_PERIOD_US * `SFSR_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire sfsr_fault_t faults,
    input wire logic init_done_lock,
    input wire logic supply_report_disable,
    input wire logic [NUM_USER_REGS*8-1:0] user_regs,
    input wire logic rd_strobe,
    input wire logic [`SFSR_ADDR_W-1:0] rd_addr,
    input wire sfsr_tx_clear_t tx_clear,
    output logic [`SFSR_DATA_W-1:0] rd_data,
    output logic memory_temp_summary_flag,
    output logic supply_timer_running
);

    localparam logic [`SFSR_RCV_CNT_W-1:0] RCV_LOAD = `SFSR_RCV_CNT_W'(RCV_CYCLES);

    sfsr_state_t s_q;
    sfsr_state_t s_d;
    logic chk_mismatch;
    logic [`SFSR_DATA_W-1:0] supply_img;
    logic [`SFSR_DATA_W-1:0] memtemp_img;
    logic rd_supply;
    logic rd_memtemp;
    logic timer_zero;
    logic supply_fault_any;
    logic seal_clr;
    // one clear per sticky bit, so a status field clears only what it reported
    logic mt_clr_f;
    logic mt_clr_u;
    logic mt_clr_rw;
    logic mt_clr_t;

    // mismatch comes one cycle after the compare, the sticky flag one cycle later
    sfsr_check_code #(
        .NUM_REGS(NUM_USER_REGS)
    ) u_check (
        .clk_sys(clk_sys),
        .rst(rst),
        .init_done_lock(init_done_lock),
        .user_regs(user_regs),
        .mismatch(chk_mismatch)
    );

    // set beats clear
    // a fault still present at the clear keeps its flag, so no report is lost
    function automatic logic sfsr_sticky(input logic q, input logic clr, input logic set);
        return (q & ~clr) | set;
    endfunction : sfsr_sticky

    function automatic logic sfsr_hit(input logic stb, input logic [`SFSR_ADDR_W-1:0] a,
                                      input logic [`SFSR_ADDR_W-1:0] off);
        return stb && (a == off);
    endfunction : sfsr_hit

    always_comb begin
        supply_img = `SFSR_REG_RST;
        supply_img[`SFSR_BIT_SEAL] = s_q.seal;
        memtemp_img = `SFSR_REG_RST;
        memtemp_img[`SFSR_BIT_FOTP] = s_q.f_otp;
        memtemp_img[`SFSR_BIT_UOTP] = s_q.u_otp;
        memtemp_img[`SFSR_BIT_URW] = s_q.u_rw;
        // live, not sticky
        // a read cannot clear it; it drops only when the write ends
        memtemp_img[`SFSR_BIT_UWACT] = faults.otp_write_busy;
        memtemp_img[`SFSR_BIT_TEMP] = s_q.temp;
    end

    assign rd_supply = sfsr_hit(rd_strobe, rd_addr, `SFSR_OFF_SUPPLY);
    assign rd_memtemp = sfsr_hit(rd_strobe, rd_addr, `SFSR_OFF_MEMTEMP);
    assign timer_zero = (s_q.rcv_cnt == '0);
    assign supply_fault_any = faults.edge_seal_break | faults.other_supply_fault;

    // clear depends on report disable
    // with reporting on, a read while the timer runs leaves the flag set:
    // the host must read again once recovery is over
    assign seal_clr = supply_report_disable ? timer_zero
                                            : (timer_zero & (rd_supply | tx_clear.supply));

    assign mt_clr_f = rd_memtemp | tx_clear.factory_otp;
    assign mt_clr_u = rd_memtemp | tx_clear.user_otp;
    assign mt_clr_rw = rd_memtemp | tx_clear.user_reg_check;
    assign mt_clr_t = rd_memtemp | tx_clear.temperature;

    always_comb begin
        s_d = s_q;

        // one shared timer
        // any supply fault restarts recovery for every supply bit at once
        if (supply_fault_any) begin
            s_d.rcv_cnt = RCV_LOAD;
        end else if (!timer_zero) begin
            s_d.rcv_cnt = s_q.rcv_cnt - `SFSR_RCV_CNT_W'(1);
        end

        s_d.seal = sfsr_sticky(s_q.seal, seal_clr, faults.edge_seal_break);

        s_d.f_otp = sfsr_sticky(s_q.f_otp, mt_clr_f, faults.factory_otp_fault);
        s_d.u_otp = sfsr_sticky(s_q.u_otp, mt_clr_u, faults.user_otp_fault);
        s_d.u_rw = sfsr_sticky(s_q.u_rw, mt_clr_rw, chk_mismatch);
        s_d.temp = sfsr_sticky(s_q.temp, mt_clr_t, faults.temperature_out_of_range);
        // set wins in every sticky bit above

        // summary of every bit
        // built from the next flag values so it moves on the same edge as the bits
        s_d.summary = s_d.f_otp | s_d.u_otp | s_d.u_rw | s_d.temp | faults.otp_write_busy;

        // registered from the next count: same timing as the count itself,
        // while the port still comes straight from a flip-flop
        s_d.timer_running = (s_d.rcv_cnt != '0);

        // a fault cleared by this very read is still reported once

        // read data shows the image before this cycle's clear
        if (rd_supply) begin
            s_d.rd_data = supply_img;
        end else if (rd_memtemp) begin
            s_d.rd_data = memtemp_img;
        end else if (rd_strobe) begin
            s_d.rd_data = `SFSR_REG_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{
                rcv_cnt: '0,
                timer_running: 1'b0,
                seal: 1'b0,
                f_otp: 1'b0,
                u_otp: 1'b0,
                u_rw: 1'b0,
                temp: 1'b0,
                summary: 1'b0,
                rd_data: `SFSR_REG_RST
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign memory_temp_summary_flag = s_q.summary;
    assign supply_timer_running = s_q.timer_running;

endmodule : sfsr_status_regs
`default_nettype wire

// ### verification/sfsr_props.sv
// Purpose: port assertions for the fault status bank
// Assumes: RCV_CYCLES is 8 in simulation
// Notes: repetition counts follow that timer length
`timescale 1ns/10ps
`default_nettype none
`include "sfsr_map.svh"
module sfsr_props
    import sfsr_pkg::*;
#(
    parameter int NUM_USER_REGS = 16,
    parameter int RCV_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire sfsr_fault_t faults,
    input wire logic init_done_lock,
    input wire logic supply_report_disable,
    input wire logic [NUM_USER_REGS*8-1:0] user_regs,
    input wire logic rd_strobe,
    input wire logic [`SFSR_ADDR_W-1:0] rd_addr,
    input wire sfsr_tx_clear_t tx_clear,
    input wire logic [`SFSR_DATA_W-1:0] rd_data,
    input wire logic memory_temp_summary_flag,
    input wire logic supply_timer_running
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic rd_sup;
    logic rd_mt;
    logic sup_f;
    logic mt_f;
    assign rd_sup = rd_strobe && rd_addr == `SFSR_OFF_SUPPLY;
    assign rd_mt = rd_strobe && rd_addr == `SFSR_OFF_MEMTEMP;
    assign sup_f = faults.edge_seal_break || faults.other_supply_fault;
    assign mt_f = faults.factory_otp_fault || faults.user_otp_fault
        || faults.temperature_out_of_range;
    seal_set_a:
        assert property (rd_sup && !$past(rst) && $past(faults.edge_seal_break)
            |=> rd_data == 8'h01) else $error("seal flag not reported");
    supply_zero_a:
        assert property (rd_sup |=> rd_data[7:1] == 7'h00) else $error("supply spare bits set");
    timer_hold_a:
        assert property (sup_f |=> supply_timer_running [*7]) else $error("timer not reloaded");
    timer_end_a:
        assert property (sup_f ##1 !sup_f [*8] |=> !supply_timer_running)
            else $error("timer overran");
    otp_set_a:
        assert property (rd_mt && !$past(rst) && $past(faults.factory_otp_fault)
            && $past(faults.user_otp_fault) |=> rd_data[7:6] == 2'b11)
            else $error("otp flags missing");
    temp_set_a:
        assert property (rd_mt && !$past(rst) && $past(faults.temperature_out_of_range)
            |=> rd_data[2]) else $error("temperature flag missing");
    read_clear_a:
        assert property (rd_mt && !mt_f ##1 !mt_f ##1 rd_mt
            |=> rd_data[7:6] == 2'b00 && !rd_data[2]) else $error("read did not clear");
    busy_live_a:
        assert property (rd_mt |=> rd_data[4] == $past(faults.otp_write_busy))
            else $error("write busy bit wrong");
    summary_flag_a:
        assert property (!$past(rst) && $past(faults.temperature_out_of_range)
            |-> memory_temp_summary_flag) else $error("summary flag low");
endmodule : sfsr_props
bind sfsr_status_regs sfsr_props #(.NUM_USER_REGS(NUM_USER_REGS), .RCV_CYCLES(RCV_CYCLES))
    u_sfsr_props (.*);
`default_nettype wire

// ### verification/sfsr_host.sv
// Purpose: host model reading status bytes
// Assumes: one read at a time, driven at falling edges
// Notes: released address shows its inverse
`timescale 1ns/10ps
`default_nettype none
module sfsr_host (
    input wire logic clk_sys,
    input wire logic rst,
    output var logic rd_strobe,
    output var logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 8'h00;
    end
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        while (rst) @(negedge clk_sys);
        rd_strobe = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_strobe = 1'b0;
        rd_addr = ~a;
        @(negedge clk_sys);
        d = rd_data;
    endtask : read
endmodule : sfsr_host
`default_nettype wire

// ### verification/tb.sv
// Purpose: directed bench for the fault status bank
// Assumes: recovery timer shortened to 8 cycles
// Notes: reads go through the host model
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sfsr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    sfsr_fault_t faults = '0;
    sfsr_tx_clear_t tx_clear = '0;
    logic lock = 1'b0;
    logic dis = 1'b0;
    logic [31:0] uregs = 32'h1234abcd;
    logic rd_strobe;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic summary;
    logic timer_on;
    int error_cnt = 0;
    int check_count = 0;
    always #25 clk_sys = ~clk_sys;
    sfsr_status_regs #(.NUM_USER_REGS(4), .RCV_CYCLES(8)) u_sfsr_status_regs (
        .clk_sys(clk_sys), .rst(rst), .faults(faults), .init_done_lock(lock),
        .supply_report_disable(dis), .user_regs(uregs), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .tx_clear(tx_clear), .rd_data(rd_data),
        .memory_temp_summary_flag(summary), .supply_timer_running(timer_on));
    sfsr_host u_sfsr_host (.clk_sys(clk_sys), .rst(rst), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .rd_data(rd_data));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_sfsr_host.read(a, d);
        cmp(d, exp);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        cyc(12);
        rst = 1'b0;
        faults.edge_seal_break = 1'b1;
        cyc(1);
        faults.edge_seal_break = 1'b0;
        cmp({7'h00, timer_on}, 8'h01);
        rd(8'h02, 8'h01);
        rd(8'h02, 8'h01);
        cyc(10);
        cmp({7'h00, timer_on}, 8'h00);
        rd(8'h02, 8'h01);
        rd(8'h02, 8'h00);
        dis = 1'b1;
        faults = 6'b110000;
        cyc(1);
        faults = '0;
        rd(8'h02, 8'h01);
        cyc(10);
        rd(8'h02, 8'h00);
        faults = 6'b001101;
        cyc(1);
        faults = '0;
        cmp({7'h00, summary}, 8'h01);
        rd(8'h03, 8'hc4);
        rd(8'h03, 8'h00);
        cmp({7'h00, summary}, 8'h00);
        faults = 6'b001101;
        cyc(1);
        faults = '0;
        tx_clear = 5'h09;
        cyc(1);
        tx_clear = '0;
        rd(8'h03, 8'h40);
        faults.user_otp_fault = 1'b1;
        cyc(1);
        faults = '0;
        tx_clear.user_otp = 1'b1;
        cyc(1);
        tx_clear = '0;
        rd(8'h03, 8'h00);
        faults.temperature_out_of_range = 1'b1;
        cyc(1);
        rd(8'h03, 8'h04);
        rd(8'h03, 8'h04);
        faults = 6'b000010;
        rd(8'h03, 8'h14);
        rd(8'h03, 8'h10);
        faults = '0;
        rd(8'h03, 8'h00);
        lock = 1'b1;
        cyc(4);
        uregs = 32'h1234abcc;
        cyc(3);
        rd(8'h03, 8'h20);
        uregs = 32'h1234abcd;
        cyc(2);
        tx_clear.user_reg_check = 1'b1;
        cyc(1);
        tx_clear = '0;
        rd(8'h03, 8'h00);
        dis = 1'b0;
        faults.edge_seal_break = 1'b1;
        cyc(1);
        faults = '0;
        tx_clear.supply = 1'b1;
        cyc(1);
        tx_clear = '0;
        rd(8'h02, 8'h01);
        cyc(10);
        tx_clear.supply = 1'b1;
        cyc(1);
        tx_clear = '0;
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h00);
        end_sim();
    end
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
